// file: nested_priority_interrupt_ctrl.sv
/*
  Nested priority interrupt controller: level bits, priority registers, external sense logic,
  arbitration and the entry sequence toward the core.
  Assumes a core that pulses instruction boundaries, stacks context on request and reports
  returns and level writes; peripherals present status flag and enable per vector.
*/
// Chosen here: the register addresses and register access over Wishbone.
// Notes on behaviour
// RULE1: Four levels, sixteen vectors max, three NMIs.
// RULE2: Vectors fixed from FFE0h to FFFFh.
// RULE3: Current level held at bits five, three.
// RULE4: Entry only after current instruction completes.
// RULE5: Entry stacks PC, X, A, CC.
// RULE6: Entry loads level from vector's priority.
// RULE7: After stacking, PC loads vector address.
// RULE8: Return restores stacked level bits.
// RULE9: Level encoding 10,01,00,11 for 0..3.
// RULE10: Highest software level first, hardware breaks ties.
// RULE11: Unserved requests stay latched until winning.
// RULE12: Reset, trap, top interrupt ignore level.
// RULE13: Trap and top interrupt force level three.
// RULE14: Non-maskable sources wake from halt.
// RULE15: Top interrupt raised on pin edge.
// RULE16: Trap like top interrupt; top preempts trap.
// RULE17: Reset routine runs level three, top hardware.
// RULE18: Maskable needs enable and higher level.
// RULE19: External sensitivity set by sense bits.
// RULE20: Edge latch cleared on entering handler.
// RULE21: Selected pins of group are NANDed.
// RULE22: Peripheral request is flag and enable.
// RULE23: Hardware priority rises toward top interrupt.
// RULE24: Arbitration re-evaluated every instruction boundary.
`timescale 1ns/10ps
`include "nested_irq_regs.svh"

module nested_priority_interrupt_ctrl
  import nested_irq_pkg::*;
#(
  parameter int NUM_VEC = 14,
  parameter int GRP_PINS = 4,
  parameter bit TLI_RISING = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_wb_err,
  input wire logic i_instr_done,
  input wire logic i_trap_exec,
  input wire logic i_return_from_irq,
  input wire logic [7:0] i_return_from_irq_cc,
  input wire logic i_cc_wr,
  input wire logic [7:0] i_cc_data,
  input wire logic i_halted,
  input wire logic i_stack_done,
  output logic o_stack_req,
  output vec_load_t o_vec_load,
  output logic o_level_bit_high,
  output logic o_level_bit_low,
  output logic o_wake,
  input wire logic i_tli_pin,
  input wire logic [2*GRP_PINS-1:0] i_ext_pin,
  input wire logic [NUM_VEC-1:0] i_periph_flag,
  input wire logic [NUM_VEC-1:0] i_periph_en
);

  localparam int VIDX_W = $clog2(NUM_VEC);
  localparam int EXT_VEC0 = `EXT0_VEC;
  localparam int EXT_VEC1 = `EXT1_VEC;

  ctl_state_t state;
  ctl_state_t next_state;
  logic [1:0] lvl;
  logic [1:0] prio [NUM_VEC];
  logic [7:0] misc [2];
  logic tli_meta, tli_sync, tli_prev, tli_pend;
  logic trap_pend;
  logic [2*GRP_PINS-1:0] ext_meta, ext_sync;
  logic [1:0] ext_prev, ext_latch;
  logic [15:0] sel_addr;
  logic [1:0] sel_lvl;
  logic sel_stacked;
  vec_load_t vec_out;
  logic ack, err;
  logic [31:0] rd_dat;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Wishbone decode

  wire wb_req = i_wb_cyc & i_wb_stb & ~ack & ~err;
  wire hit_prio = (i_wb_adr[7:4] == 4'h0) & (i_wb_adr[1:0] == 2'h0);
  wire hit_misc0 = (i_wb_adr == `ADR_MISC_FIRST);
  wire hit_misc1 = (i_wb_adr == `ADR_MISC_THIRD);
  wire hit_stat = (i_wb_adr == `ADR_STATUS);
  wire wb_hit = hit_prio | hit_misc0 | hit_misc1 | hit_stat;
  wire wr_go = wb_req & wb_hit & i_wb_we & i_wb_sel[0];
  wire [31:0] prio_flat;
  wire [NUM_VEC-1:0] req;
  wire [NUM_VEC-1:0] elig;
  wire [1:0] vrank [NUM_VEC];
  wire [1:0] cur_rank = lvl_rank(lvl);
  wire busy = (state != S_RUN);
  wire [31:0] stat_word = (32'({trap_pend, tli_pend, busy, lvl}) << `STAT_LVL_LSB) | 32'(req);
  wire [7:0] prio_byte = prio_flat[{i_wb_adr[3:2], 3'h0} +: 8];

  assign rd_dat = hit_prio ? {24'h0, prio_byte} :
                  hit_misc0 ? {24'h0, misc[0]} :
                  hit_misc1 ? {24'h0, misc[1]} :
                  hit_stat ? stat_word : 32'h0;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack <= 1'b0;
      err <= 1'b0;
      o_wb_dat <= 32'h0;
    end else if (i_ce) begin
      ack <= wb_req & wb_hit;
      err <= wb_req & ~wb_hit;
      o_wb_dat <= (wb_req & wb_hit & ~i_wb_we) ? rd_dat : 32'h0;
    end
  end

  assign o_wb_ack = ack;
  assign o_wb_err = err;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Sense control: one register per external group

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_misc
      wire hit_m = g == 0 ? hit_misc0 : hit_misc1;
      always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn)
          misc[g] <= `MISC_RESET;
        else if (i_ce && wr_go && hit_m)
          misc[g] <= i_wb_dat[7:0]; // RULE19
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and external groups

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      tli_meta <= 1'b0;
      tli_sync <= 1'b0;
      tli_prev <= 1'b0;
      ext_meta <= '1;
      ext_sync <= '1;
    end else if (i_ce) begin
      tli_meta <= i_tli_pin;
      tli_sync <= tli_meta;
      tli_prev <= tli_sync;
      ext_meta <= i_ext_pin;
      ext_sync <= ext_meta;
    end
  end

  wire tli_edge = TLI_RISING ? (tli_sync & ~tli_prev) : (~tli_sync & tli_prev); // RULE15
  wire [1:0] ext_req;
  wire [1:0] ext_clr;

  generate
    for (g = 0; g < 2; g++) begin : g_ext
      wire [GRP_PINS-1:0] pins = ext_sync[g*GRP_PINS +: GRP_PINS];
      wire [GRP_PINS-1:0] sel = misc[g][`MISC_SEL_LSB +: GRP_PINS];
      wire [1:0] sense = misc[g][`MISC_SENSE_LSB +: 2];
      wire comb = ~&(pins | ~sel); // RULE21
      wire edge_hit = (sense == `SENSE_RISE) ? (comb & ~ext_prev[g]) :
                      (sense == `SENSE_FALL) ? (~comb & ext_prev[g]) :
                      (sense == `SENSE_BOTH) ? (comb ^ ext_prev[g]) : 1'b0;
      assign ext_req[g] = (sense == `SENSE_LEVEL) ? comb : ext_latch[g]; // RULE19
      always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
          ext_prev[g] <= 1'b0;
          ext_latch[g] <= 1'b0;
        end else if (i_ce) begin
          ext_prev[g] <= comb;
          ext_latch[g] <= edge_hit | (ext_latch[g] & ~ext_clr[g]); // RULE20
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Per-vector priority, request and eligibility

  wire [VIDX_W-1:0] win_idx;
  logic win_ok;
  logic [VIDX_W-1:0] win_v;
  logic [1:0] win_rank;
  wire take_tli = tli_pend;
  wire take_trap = trap_pend & ~tli_pend; // RULE16
  wire nmi_take = take_tli | take_trap; // RULE12
  wire any_take = nmi_take | win_ok;
  wire entry_fire = i_ce & (state == S_RUN) & i_instr_done & any_take; // RULE4 RULE24
  wire prio_wr = wr_go & hit_prio;

  assign win_idx = win_v;
  assign ext_clr[0] = entry_fire & ~nmi_take & (32'(win_idx) == EXT_VEC0); // RULE20
  assign ext_clr[1] = entry_fire & ~nmi_take & (32'(win_idx) == EXT_VEC1);

  genvar v;
  generate
    for (v = 0; v < 16; v++) begin : g_vec // RULE1
      if (v < NUM_VEC) begin : g_live
        assign prio_flat[2*v +: 2] = prio[v];
        assign vrank[v] = lvl_rank(prio[v]);
        if (v == `TLI_VEC) begin : g_tli
          assign req[v] = tli_pend;
          assign elig[v] = 1'b0;
        end else begin : g_mask
          if (v == EXT_VEC0) begin : g_e0
            assign req[v] = ext_req[0];
          end else if (v == EXT_VEC1) begin : g_e1
            assign req[v] = ext_req[1];
          end else begin : g_per
            assign req[v] = i_periph_flag[v] & i_periph_en[v]; // RULE22
          end
          assign elig[v] = req[v] & (vrank[v] > cur_rank); // RULE18 RULE9
        end
        always_ff @(posedge i_mclk or negedge i_rstn) begin
          if (!i_rstn)
            prio[v] <= `PRIO_RESET;
          else if (i_ce && prio_wr && i_wb_adr[3:2] == 2'(v / 4) &&
                   i_wb_dat[2*(v%4) +: 2] != `LVL_MAIN)
            prio[v] <= i_wb_dat[2*(v%4) +: 2];
        end
      end else begin : g_fill
        assign prio_flat[2*v +: 2] = 2'h3;
      end
    end
  endgenerate

  // Lowest index wins a tie since it is visited last
  always_comb begin
    win_ok = 1'b0;
    win_v = '0;
    win_rank = 2'h0;
    for (int k = NUM_VEC - 1; k >= 1; k--) begin
      if (elig[k] && (!win_ok || vrank[k] >= win_rank)) begin // RULE10 RULE23
        win_ok = 1'b1;
        win_v = VIDX_W'(k);
        win_rank = vrank[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Non-maskable latches

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      tli_pend <= 1'b0;
      trap_pend <= 1'b0;
    end else if (i_ce) begin
      tli_pend <= tli_edge | (tli_pend & ~(entry_fire & take_tli)); // RULE11
      trap_pend <= i_trap_exec | (trap_pend & ~(entry_fire & take_trap));
    end
  end

  assign o_wake = i_halted & (tli_pend | trap_pend); // RULE14

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Entry sequence

  always_comb begin
    next_state = state;
    case (state)
      S_RESET: next_state = S_VECTOR; // RULE17
      S_RUN: if (entry_fire) next_state = S_STACK;
      S_STACK: if (i_stack_done) next_state = S_VECTOR; // RULE5
      S_VECTOR: next_state = S_RUN; // RULE7
      default: next_state = S_RUN;
    endcase
  end

  wire [15:0] mask_addr = `VEC_TOP - 16'({win_idx, 1'b0}); // RULE2
  wire [15:0] take_addr = take_tli ? `VEC_TOP : take_trap ? `VEC_TRAP : mask_addr;
  wire [1:0] take_lvl = nmi_take ? `LVL_DISABLE : prio[win_idx]; // RULE6 RULE13

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= S_RESET;
      sel_addr <= `VEC_RESET;
      sel_lvl <= `LVL_DISABLE;
      sel_stacked <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      if (entry_fire) begin
        sel_addr <= take_addr;
        sel_lvl <= take_lvl;
        sel_stacked <= 1'b1;
      end
    end
  end

  assign o_stack_req = (state == S_STACK); // RULE5

  // Level bits change together with the vector load, after the old value was stacked
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      vec_out <= '0;
      lvl <= `LVL_DISABLE; // RULE17
    end else if (i_ce) begin
      vec_out.valid <= (state == S_VECTOR);
      if (state == S_VECTOR) begin
        vec_out.addr <= sel_addr; // RULE7
        vec_out.level <= sel_lvl;
        vec_out.stacked <= sel_stacked;
        lvl <= sel_lvl; // RULE6 RULE3
      end else if (i_return_from_irq) begin
        lvl <= {i_return_from_irq_cc[`CC_LVL_HI_BIT], i_return_from_irq_cc[`CC_LVL_LO_BIT]}; // RULE8
      end else if (i_cc_wr) begin
        lvl <= {i_cc_data[`CC_LVL_HI_BIT], i_cc_data[`CC_LVL_LO_BIT]}; // RULE3
      end
    end
  end

  assign o_vec_load = vec_out;
  assign o_level_bit_high = lvl[1];
  assign o_level_bit_low = lvl[0];

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  entry_at_boundary_a: assert property ($rose(o_stack_req) |-> $past(i_instr_done)) // RULE4
    else $error("entry started without an instruction boundary");
  level_follows_load_a: assert property (o_vec_load.valid |-> lvl == o_vec_load.level) // RULE6
    else $error("level bits differ from loaded level");
  nmi_level_three_a: assert property (o_vec_load.valid && o_vec_load.addr >= `VEC_TOP
                                      |-> o_vec_load.level == `LVL_DISABLE) // RULE13
    else $error("non-maskable entry not at level three");
  vector_in_range_a: assert property (o_vec_load.valid |-> o_vec_load.addr >= `VEC_BOTTOM
                                      && !o_vec_load.addr[0]) // RULE2
    else $error("vector outside the vector region");
  stack_then_vector_a: assert property ($fell(o_stack_req) && i_rstn |-> state == S_VECTOR ##1
                                        o_vec_load.valid || !$past(i_ce)) // RULE7
    else $error("stacking not followed by vector load");
  return_from_irq_restores_a: assert property (i_ce && i_return_from_irq && state == S_RUN
                                    |=> lvl == {$past(i_return_from_irq_cc[5]), $past(i_return_from_irq_cc[3])}) // RULE8
    else $error("return did not restore level bits");
  level3_masks_a: assert property (i_ce && state == S_RUN && i_instr_done && lvl == `LVL_DISABLE
                                   && !tli_pend && !trap_pend |=> state == S_RUN) // RULE12
    else $error("maskable request taken at level three");
  tli_edge_latch_a: assert property (i_ce && tli_edge |=> tli_pend) // RULE15
    else $error("top interrupt edge not latched");
  nmi_wakes_a: assert property (i_halted && (tli_pend || trap_pend) |-> o_wake) // RULE14
    else $error("non-maskable source did not wake");
  reset_vector_a: assert property ($rose(i_rstn) |-> ##[1:4] o_vec_load.valid
                                   && o_vec_load.addr == `VEC_RESET) // RULE17
    else $error("reset vector not loaded");
  trap_held_a: assert property (trap_pend && !(entry_fire && take_trap) |=> trap_pend) // RULE11
    else $error("pending trap dropped without entry");

  tli_entry_c: cover property (o_vec_load.valid && o_vec_load.addr == `VEC_TOP);
  trap_entry_c: cover property (o_vec_load.valid && o_vec_load.addr == `VEC_TRAP);
  mask_entry_c: cover property (o_vec_load.valid && o_vec_load.addr < `VEC_TOP);
  nested_return_from_irq_c: cover property (i_return_from_irq && state == S_RUN && lvl != `LVL_MAIN);

endmodule // nested_priority_interrupt_ctrl

// file: nested_irq_regs.svh
/*
  Offsets, field positions, reset values and encodings of the nested priority interrupt controller.
  Assumes a word-addressed Wishbone slave with an 8-bit byte address; included by bare name.
*/
`ifndef NESTED_IRQ_REGS_SVH
`define NESTED_IRQ_REGS_SVH

// Register byte offsets
`define ADR_PRIO0 8'h00
`define ADR_PRIO3 8'h0C
`define ADR_MISC_FIRST 8'h10
`define ADR_MISC_THIRD 8'h14
`define ADR_STATUS 8'h18

// Reset values
`define PRIO_RESET 2'h3
`define MISC_RESET 8'h00

// Level encodings {level_bit_high, level_bit_low}
`define LVL_MAIN 2'h2
`define LVL_DISABLE 2'h3
`define CC_LVL_HI_BIT 5
`define CC_LVL_LO_BIT 3

// Vector addresses
`define VEC_RESET 16'hFFFE
`define VEC_TRAP 16'hFFFC
`define VEC_TOP 16'hFFFA
`define VEC_BOTTOM 16'hFFE0

// Misc control fields and sense encodings
`define MISC_SENSE_LSB 0
`define MISC_SEL_LSB 4
`define SENSE_LEVEL 2'h0
`define SENSE_RISE 2'h1
`define SENSE_FALL 2'h2
`define SENSE_BOTH 2'h3

// Vector indices of fixed sources
`define TLI_VEC 0
`define EXT0_VEC 2
`define EXT1_VEC 6

// Status word field positions
`define STAT_LVL_LSB 16

`endif

// file: nested_irq_pkg.sv
/*
  Types shared by the nested priority interrupt controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nested_irq_pkg;

  typedef enum logic [1:0] {S_RESET, S_RUN, S_STACK, S_VECTOR} ctl_state_t;

  // One vector load presented to the core
  typedef struct packed {
    logic valid;
    logic stacked;
    logic [15:0] addr;
    logic [1:0] level;
  } vec_load_t;

  // Rank of a level encoding: 10 -> 0, 01 -> 1, 00 -> 2, 11 -> 3
  function automatic logic [1:0] lvl_rank(input logic [1:0] l);
    return {~(l[1] ^ l[0]), l[0]};
  endfunction

endpackage

// file: core_model.sv
/*
  Behavioural core for the interrupt controller bench: instruction boundaries and context stacking.
  Assumes the controller's stack request and done handshake on the same clock and reset.
*/
`timescale 1ns/10ps
module core_model (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_run,
  input wire logic i_slow,
  input wire logic i_stack_req,
  output logic o_instr_done,
  output logic o_stack_done
);
  logic [1:0] phase;
  logic [2:0] wait_cnt;
  logic [2:0] wait_len;
  assign wait_len = i_slow ? 3'h4 : 3'h0;
  ////////////////////////////////////////////////////////////////
  // One instruction ends every fourth cycle, none while stacking
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase <= 2'h0;
      o_instr_done <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      o_instr_done <= i_run && !i_stack_req && (phase == 2'h3);
    end
  end
  ////////////////////////////////////////////////////////////////
  // Pushes PC, X, A and CC, promptly or after a delay
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_cnt <= 3'h0;
      o_stack_done <= 1'b0;
    end else if (i_stack_req && !o_stack_done && wait_cnt != wait_len) begin
      wait_cnt <= wait_cnt + 3'h1;
    end else begin
      o_stack_done <= i_stack_req && !o_stack_done;
      wait_cnt <= 3'h0;
    end
  end
endmodule // core_model

// file: nested_priority_interrupt_ctrl_tb.sv
/*
  Self-checking bench of the nested priority interrupt controller.
  Assumes the package, register header, design and core model are compiled first.
*/
`timescale 1ns/10ps
`include "nested_irq_regs.svh"
module nested_priority_interrupt_ctrl_tb;
  import nested_irq_pkg::*;
  logic clk, rstn, cyc, stb, we, ack, err, run, slow, trap, return_from_irq, cc_wr, halt, sdone, sreq, done, lhi, llo, wake, top_level_hw_irq;
  logic ce;
  logic [7:0] adr, cc_d, ext;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [13:0] flag, en;
  vec_load_t vl;
  int n_mismatch, num_checks;

  nested_priority_interrupt_ctrl nested_priority_interrupt_ctrl_inst (.i_mclk(clk), .i_rstn(rstn), .i_ce(ce),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err), .i_instr_done(done), .i_trap_exec(trap), .i_return_from_irq(return_from_irq),
    .i_return_from_irq_cc(cc_d), .i_cc_wr(cc_wr), .i_cc_data(cc_d), .i_halted(halt), .i_stack_done(sdone),
    .o_stack_req(sreq), .o_vec_load(vl), .o_level_bit_high(lhi), .o_level_bit_low(llo), .o_wake(wake),
    .i_tli_pin(top_level_hw_irq), .i_ext_pin(ext), .i_periph_flag(flag), .i_periph_en(en));
  core_model core_model_inst (.i_mclk(clk), .i_rstn(rstn), .i_run(run), .i_slow(slow), .i_stack_req(sreq),
    .o_instr_done(done), .o_stack_done(sdone));
  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic miss(input string m);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) miss($sformatf("got %h want %h", got, exp));
  endtask
  // One classic Wishbone cycle; ack and err are sampled at the edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                    output logic e);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    if (i == 20) begin
      miss("bus timeout");
      end_sim();
    end
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    wb(1'b1, a, d, q, e);
    chk(32'(e), 32'h0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    wb(1'b0, a, 32'h0, q, e);
    chk(q & m, x);
    chk(32'(e), 32'(xe));
  endtask
  task automatic cc(input logic [7:0] d, input logic ret);
    cc_d <= d;
    cc_wr <= !ret;
    return_from_irq <= ret;
    @(posedge clk);
    cc_wr <= 1'b0;
    return_from_irq <= 1'b0;
    @(posedge clk);
  endtask
  // Waits for a vector load and checks its address, level and the level bits
  task automatic wait_vec(input logic [15:0] a, input logic [1:0] l);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (vl.valid === 1'b1) break;
    end
    if (i == 300) begin
      miss("no vector load");
      end_sim();
    end
    chk(32'(vl.addr), 32'(a));
    chk(32'({vl.level, lhi, llo}), 32'({l, l}));
    chk(32'(vl.stacked), 32'(a != `VEC_RESET));
  endtask
  task automatic no_vec(input int n);
    num_checks++;
    repeat (n) begin
      @(posedge clk);
      if (vl.valid !== 1'b0) miss("vector load not expected");
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rstn, cyc, stb, we, run, slow, trap, return_from_irq, cc_wr, halt, top_level_hw_irq} = '0;
    adr = 8'h00;
    cc_d = 8'h00;
    wdat = 32'h0;
    sel = 4'hF;
    ce = 1'b1;
    ext = 8'hFF;
    flag = '0;
    en = '0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    wait_vec(`VEC_RESET, 2'h3);
    rd_chk(`ADR_STATUS, 32'h001F3FFF, 32'h00030000, 1'b0);
    rd_chk(8'h40, 32'h0, 32'h0, 1'b1);
    rd_chk(`ADR_PRIO0, 32'hFF, 32'hFF, 1'b0);
    wr(`ADR_PRIO0, 32'h7F);
    wr(`ADR_PRIO0, 32'hBF);
    rd_chk(`ADR_PRIO0, 32'hFF, 32'h7F, 1'b0);
    wr(8'h04, 32'hC4);
    run <= 1'b1;
    cc(8'h20, 1'b0);
    chk(32'({lhi, llo}), 32'h2);
    slow <= 1'b1;
    flag[3] <= 1'b1;
    en[3] <= 1'b1;
    wait_vec(16'hFFF4, 2'h1);
    flag[3] <= 1'b0;
    slow <= 1'b0;
    flag[5:4] <= 2'h3;
    en[5:4] <= 2'h3;
    wait_vec(16'hFFF2, 2'h0);
    flag[4] <= 1'b0;
    cc(8'h08, 1'b1);
    chk(32'({lhi, llo}), 32'h1);
    no_vec(40);
    rd_chk(`ADR_STATUS, 32'h20, 32'h20, 1'b0);
    cc(8'h20, 1'b1);
    wait_vec(16'hFFF0, 2'h1);
    flag[5] <= 1'b0;
    cc(8'h28, 1'b0);
    top_level_hw_irq <= 1'b1;
    wait_vec(`VEC_TOP, 2'h3);
    trap <= 1'b1;
    @(posedge clk);
    trap <= 1'b0;
    wait_vec(`VEC_TRAP, 2'h3);
    run <= 1'b0;
    halt <= 1'b1;
    top_level_hw_irq <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(wake), 32'h0);
    trap <= 1'b1;
    top_level_hw_irq <= 1'b1;
    @(posedge clk);
    trap <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(wake), 32'h1);
    halt <= 1'b0;
    run <= 1'b1;
    wait_vec(`VEC_TOP, 2'h3);
    wait_vec(`VEC_TRAP, 2'h3);
    wr(`ADR_PRIO0, 32'h4F);
    wr(`ADR_MISC_FIRST, 32'h30);
    cc(8'h20, 1'b0);
    ext[0] <= 1'b0;
    wait_vec(16'hFFF6, 2'h0);
    ext[0] <= 1'b1;
    wr(`ADR_MISC_THIRD, 32'h13);
    cc(8'h20, 1'b0);
    ext[4] <= 1'b0;
    wait_vec(16'hFFEE, 2'h0);
    cc(8'h20, 1'b0);
    ce <= 1'b0;
    cc(8'h28, 1'b0);
    chk(32'({lhi, llo}), 32'h2);
    ce <= 1'b1;
    no_vec(40);
    wr(`ADR_MISC_THIRD, 32'h12);
    ext[4] <= 1'b1;
    wait_vec(16'hFFEE, 2'h0);
    cc(8'h20, 1'b0);
    wr(`ADR_MISC_THIRD, 32'h11);
    ext[4] <= 1'b0;
    wait_vec(16'hFFEE, 2'h0);
    end_sim();
  end
endmodule // nested_priority_interrupt_ctrl_tb
